// file: rtl/scm_addr_map.v
// configuration space address decoder and access arbiter
`timescale 1ns/10ps
`default_nettype none
`include "scm_defs.vh"

module scm_addr_map
(
  // clock and reset
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire        ce,
  // pcie configuration access
  input  wire        cfg_req,
  input  wire        cfg_we,
  input  wire [2:0]  cfg_port,
  input  wire [11:0] cfg_off,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  output reg         cfg_ack_r,
  output reg  [31:0] cfg_rdata_r,
  // slave smbus access
  input  wire        smb_req,
  input  wire        smb_we,
  input  wire [15:0] smb_addr,
  input  wire [3:0]  smb_be,
  input  wire [31:0] smb_wdata,
  output reg         smb_ack_r,
  output reg  [31:0] smb_rdata_r,
  // eeprom loader writes
  input  wire        eep_req,
  input  wire [15:0] eep_addr,
  input  wire [3:0]  eep_be,
  input  wire [31:0] eep_wdata,
  output reg         eep_ack_r,
  // status of the acknowledged access
  output reg         acc_undef_r
);

  // ****************************************************************
  // states and sources
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_MEM  = 2'b01;
  localparam [1:0] ST_RESP = 2'b10;
  localparam [1:0] ST_ACK  = 2'b11;

  localparam [1:0] SRC_NONE = 2'b00;
  localparam [1:0] SRC_CFG  = 2'b01;
  localparam [1:0] SRC_SMB  = 2'b10;
  localparam [1:0] SRC_EEP  = 2'b11;

  // ****************************************************************
  // decode functions
  // ****************************************************************
  // pcie view: port base plus offset
  function [15:0] sys_addr;
    input [2:0]  port;
    input [11:0] off;
    begin
      sys_addr = `SCM_US_BASE + (`SCM_PORT_STEP * {13'h0000, port})
                 + {4'h0, off};
    end
  endfunction

  function in_rng;
    input [11:0] o;
    input [11:0] lo;
    input [11:0] hi;
    begin
      in_rng = (o >= lo) && (o <= hi);
    end
  endfunction

  // one decode shared by all three sources
  function addr_def;
    input [15:0] a;
    reg   [3:0]  p;
    reg   [11:0] o;
    reg          us;
    begin
      p  = a[`SCM_PORT_MSB:`SCM_PORT_LSB];
      o  = a[`SCM_OFF_MSB:0];
      us = (p == `SCM_US_PORT);
      addr_def = 1'b0;
      if (p <= `SCM_LAST_PORT)
      begin
        if (in_rng(o, `SCM_HDR_LO, `SCM_HDR_HI) ||
            in_rng(o, `SCM_PM_LO, `SCM_PM_HI) ||
            in_rng(o, `SCM_ECFG_LO, `SCM_ECFG_HI) ||
            in_rng(o, `SCM_AER_LO, `SCM_AER_HI))
        begin
          addr_def = 1'b1;
        end
        if (us && (in_rng(o, `SCM_GLB_LO, `SCM_GLB_HI) ||
                   in_rng(o, `SCM_TEST_LO, `SCM_TEST_HI)))
        begin
          addr_def = 1'b1;
        end
        if (!us && in_rng(o, `SCM_MSI_LO, `SCM_MSI_HI))
        begin
          addr_def = 1'b1;
        end
      end
    end
  endfunction

  // storage word: port code above dword index
  function [12:0] mem_idx;
    input [15:0] a;
    begin
      mem_idx = {a[`SCM_PORT_LSB+2:`SCM_PORT_LSB], a[`SCM_OFF_MSB:`SCM_DW_LSB]};
    end
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg [1:0]  src_r;
  reg [1:0]  src_nxt;
  reg        we_r;
  reg        we_nxt;
  reg        def_r;
  reg        def_nxt;
  reg [12:0] idx_r;
  reg [12:0] idx_nxt;
  reg [3:0]  be_r;
  reg [3:0]  be_nxt;
  reg [31:0] wdata_r;
  reg [31:0] wdata_nxt;
  reg [31:0] resp_nxt;

  wire [31:0] mem_rdata;
  wire [15:0] cfg_sys;
  wire        mem_rd;
  wire        mem_wr;

  assign cfg_sys = sys_addr(cfg_port, cfg_off);

  // undefined offsets never touch storage
  assign mem_rd = (state_r == ST_MEM) && !we_r && def_r;
  assign mem_wr = (state_r == ST_MEM) && we_r && def_r;

  // ****************************************************************
  // next state
  // ****************************************************************
  always @*
  begin
    state_nxt = state_r;
    src_nxt   = src_r;
    we_nxt    = we_r;
    def_nxt   = def_r;
    idx_nxt   = idx_r;
    be_nxt    = be_r;
    wdata_nxt = wdata_r;
    case (state_r)
      ST_IDLE:
      begin
        // loader first: it only runs while the switch initialises
        if (eep_req)
        begin
          state_nxt = ST_MEM;
          src_nxt   = SRC_EEP;
          we_nxt    = 1'b1;
          def_nxt   = addr_def(eep_addr);
          idx_nxt   = mem_idx(eep_addr);
          be_nxt    = eep_be;
          wdata_nxt = eep_wdata;
        end
        else if (cfg_req)
        begin
          state_nxt = ST_MEM;
          src_nxt   = SRC_CFG;
          we_nxt    = cfg_we;
          def_nxt   = addr_def(cfg_sys);
          idx_nxt   = mem_idx(cfg_sys);
          be_nxt    = cfg_be;
          wdata_nxt = cfg_wdata;
        end
        else if (smb_req)
        begin
          state_nxt = ST_MEM;
          src_nxt   = SRC_SMB;
          we_nxt    = smb_we;
          def_nxt   = addr_def(smb_addr);
          idx_nxt   = mem_idx(smb_addr);
          be_nxt    = smb_be;
          wdata_nxt = smb_wdata;
        end
      end
      ST_MEM:
      begin
        state_nxt = ST_RESP;
      end
      ST_RESP:
      begin
        state_nxt = ST_ACK;
      end
      ST_ACK:
      begin
        // one quiet cycle lets the requester drop its request
        state_nxt = ST_IDLE;
        src_nxt   = SRC_NONE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
        src_nxt   = SRC_NONE;
      end
    endcase
  end

  // ****************************************************************
  // read answer
  // ****************************************************************
  always @*
  begin
    if (we_r)
    begin
      resp_nxt = `SCM_ZERO_DATA;
    end
    else if (def_r)
    begin
      resp_nxt = mem_rdata;
    end
    else if (src_r == SRC_SMB)
    begin
      resp_nxt = `SCM_SMB_UNDEF;
    end
    else
    begin
      resp_nxt = `SCM_ZERO_DATA;
    end
  end

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_IDLE;
      src_r   <= SRC_NONE;
      we_r    <= 1'b0;
      def_r   <= 1'b0;
      idx_r   <= 13'h0000;
      be_r    <= 4'h0;
      wdata_r <= `SCM_RST_DATA;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      src_r   <= src_nxt;
      we_r    <= we_nxt;
      def_r   <= def_nxt;
      idx_r   <= idx_nxt;
      be_r    <= be_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // ****************************************************************
  // answers to the three sources
  // ****************************************************************
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_ack_r   <= 1'b0;
      smb_ack_r   <= 1'b0;
      eep_ack_r   <= 1'b0;
      acc_undef_r <= 1'b0;
      cfg_rdata_r <= `SCM_RST_DATA;
      smb_rdata_r <= `SCM_RST_DATA;
    end
    else if (ce)
    begin
      cfg_ack_r <= 1'b0;
      smb_ack_r <= 1'b0;
      eep_ack_r <= 1'b0;
      if (state_r == ST_RESP)
      begin
        // writes to undefined offsets still complete
        acc_undef_r <= !def_r;
        case (src_r)
          SRC_CFG:
          begin
            cfg_ack_r   <= 1'b1;
            cfg_rdata_r <= resp_nxt;
          end
          SRC_SMB:
          begin
            smb_ack_r   <= 1'b1;
            smb_rdata_r <= resp_nxt;
          end
          SRC_EEP:
          begin
            eep_ack_r <= 1'b1;
          end
          default:
          begin
            eep_ack_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // storage
  // ****************************************************************
  scm_cfg_mem u_mem
  (
    .clk_sys (clk_sys),
    .ce      (ce),
    .rd_en   (mem_rd),
    .wr_en   (mem_wr),
    .addr    (idx_r),
    .be      (be_r),
    .wdata   (wdata_r),
    .rdata_r (mem_rdata)
  );

endmodule // scm_addr_map
`default_nettype wire

// file: rtl/scm_cfg_mem.v
// register storage of all seven port configuration spaces
`timescale 1ns/10ps
`default_nettype none
`include "scm_defs.vh"

module scm_cfg_mem
(
  // clock
  input  wire        clk_sys,
  input  wire        ce,
  // access
  input  wire        rd_en,
  input  wire        wr_en,
  input  wire [12:0] addr,
  input  wire [3:0]  be,
  input  wire [31:0] wdata,
  // read data
  output reg  [31:0] rdata_r
);

  // ****************************************************************
  // byte lane storage and writes
  // ****************************************************************
  // one array per lane, so each array has a single writing process
  wire [31:0] lane_q;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      reg [7:0] lane [0:`SCM_MEM_DEPTH-1];
      always @(posedge clk_sys)
      begin
        if (ce && wr_en && be[g])
        begin
          lane[addr] <= wdata[8*g+7:8*g];
        end
      end
      assign lane_q[8*g+7:8*g] = lane[addr];
    end
  endgenerate

  // ****************************************************************
  // registered read
  // ****************************************************************
  always @(posedge clk_sys)
  begin
    if (ce && rd_en)
    begin
      rdata_r <= lane_q;
    end
  end

endmodule // scm_cfg_mem
`default_nettype wire

// file: rtl/scm_defs.vh
// constants of the switch configuration space address map
// How it works
// - every register lives in one port's configuration space, root reaches all
// - system address equals port base plus configuration offset
// - eeprom loader and smbus select registers by system address
// - upstream port configuration space sits at base zero
// - downstream ports one to six sit at 0x1000 steps up to 0x6000
// - global control, status and test registers exist only upstream
// - msi capability exists only in downstream ports
// - pcie read of undefined offset completes returning zero
// - smbus read of undefined offset returns all ones (0xFFFFFFFF)
// - write to undefined offset completes, changes nothing, no side effect
`ifndef SCM_DEFS_VH
`define SCM_DEFS_VH

// ****************************************************************
// address layout
// ****************************************************************
`define SCM_PORT_MSB    15
`define SCM_PORT_LSB    12
`define SCM_OFF_MSB     11
`define SCM_DW_LSB      2
`define SCM_US_PORT     4'h0
`define SCM_LAST_PORT   4'h6
`define SCM_US_BASE     16'h0000
`define SCM_PORT_STEP   16'h1000
`define SCM_MEM_DEPTH   7168

// ****************************************************************
// defined offset regions
// ****************************************************************
`define SCM_HDR_LO      12'h000
`define SCM_HDR_HI      12'h073
`define SCM_PM_LO       12'h0C0
`define SCM_PM_HI       12'h0C7
`define SCM_MSI_LO      12'h0D0
`define SCM_MSI_HI      12'h0DF
`define SCM_ECFG_LO     12'h0F8
`define SCM_ECFG_HI     12'h0FF
`define SCM_AER_LO      12'h100
`define SCM_AER_HI      12'h14F
`define SCM_GLB_LO      12'h400
`define SCM_GLB_HI      12'h4FF
`define SCM_TEST_LO     12'h500
`define SCM_TEST_HI     12'h5FF

// ****************************************************************
// read answers and reset values
// ****************************************************************
`define SCM_ZERO_DATA   32'h00000000
`define SCM_SMB_UNDEF   32'hFFFFFFFF
`define SCM_RST_DATA    32'h00000000

`endif

// file: verif/scm_addr_map_checker.sv
// assertions on the ports of the configuration address map
`timescale 1ns/10ps
`default_nettype none
module scm_addr_map_checker
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        arst_n,
  // pcie side
  input wire logic        cfg_req,
  input wire logic        cfg_we,
  input wire logic [2:0]  cfg_port,
  input wire logic [11:0] cfg_off,
  input wire logic        cfg_ack_r,
  input wire logic [31:0] cfg_rdata_r,
  // smbus and loader side
  input wire logic        smb_we,
  input wire logic [15:0] smb_addr,
  input wire logic        smb_ack_r,
  input wire logic [31:0] smb_rdata_r,
  input wire logic        eep_req,
  input wire logic        eep_ack_r,
  input wire logic        acc_undef_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ********
  // answers
  // ********
  one_ack_a: assert property ($onehot0({cfg_ack_r, smb_ack_r, eep_ack_r}))
    else $error("two sources answered at once");
  cfg_ack_cause_a: assert property ($rose(cfg_ack_r) |-> $past(cfg_req, 3))
    else $error("pcie answer without request three edges before");
  eep_ack_pulse_a: assert property ($rose(eep_ack_r) |-> $past(eep_req, 3) ##1 !eep_ack_r)
    else $error("loader answer early or not one cycle");
  cfg_hold_data_a: assert property (!cfg_ack_r |-> $stable(cfg_rdata_r))
    else $error("pcie read data moved without answer");
  // ********
  // decode
  // ********
  port_seven_a: assert property (cfg_ack_r && cfg_port == 3'h7 |-> acc_undef_r)
    else $error("pcie port seven decoded");
  up_msi_zero_a: assert property (cfg_ack_r && !cfg_we && cfg_port == 3'h0
    && cfg_off[11:4] == 8'h0D |-> acc_undef_r && cfg_rdata_r == 32'h0)
    else $error("upstream msi offset not zero");
  dn_global_a: assert property (cfg_ack_r && cfg_port != 3'h0
    && cfg_off[11:9] == 3'h2 |-> acc_undef_r)
    else $error("downstream global offset decoded");
  up_global_a: assert property (cfg_ack_r && cfg_port == 3'h0
    && cfg_off[11:9] == 3'h2 |-> !acc_undef_r)
    else $error("upstream global offset undefined");
  smb_port_a: assert property (smb_ack_r && smb_addr[15:12] > 4'h6 |-> acc_undef_r)
    else $error("smbus port code above six decoded");
  smb_header_a: assert property (smb_ack_r && smb_addr[15:12] <= 4'h6
    && smb_addr[11:0] < 12'h074 |-> !acc_undef_r)
    else $error("smbus header offset undefined");
  smb_undef_a: assert property (smb_ack_r && !smb_we && acc_undef_r
    |-> smb_rdata_r == 32'hFFFFFFFF)
    else $error("smbus undefined read value");
endmodule // scm_addr_map_checker

bind scm_addr_map scm_addr_map_checker u_chk
(
  .clk_sys, .arst_n, .cfg_req, .cfg_we, .cfg_port, .cfg_off, .cfg_ack_r, .cfg_rdata_r,
  .smb_we, .smb_addr, .smb_ack_r, .smb_rdata_r, .eep_req, .eep_ack_r, .acc_undef_r
);
`default_nettype wire

// file: verif/scm_req_model.sv
// requester model for one access source of the address map
`timescale 1ns/10ps
`default_nettype none
module scm_req_model
(
  // clock and answer
  input  wire logic        clk_sys,
  input  wire logic        ack,
  input  wire logic [31:0] rdata,
  // request
  output var  logic        req,
  output var  logic        we,
  output var  logic [15:0] addr,
  output var  logic [3:0]  be,
  output var  logic [31:0] wdata
);
  initial
  begin
    {req, we, addr, be, wdata} = '0;
  end
  // ********
  // access
  // ********
  // held until ack is sampled, then one idle edge so the drop is seen
  task automatic access(input logic w, input logic [15:0] a, input logic [3:0] b,
                        input logic [31:0] d, output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    req   <= 1'b1;
    we    <= w;
    addr  <= a;
    be    <= b;
    wdata <= d;
    @(posedge clk_sys);
    while (ack !== 1'b1 && n < 16)
    begin
      @(posedge clk_sys);
      n++;
    end
    ok = (ack === 1'b1);
    q = rdata;
    req <= 1'b0;
    // released lines flip so a stale value cannot pass for a held one
    {we, addr, be, wdata} <= ~{w, a, b, d};
    @(posedge clk_sys);
  endtask
endmodule // scm_req_model
`default_nettype wire

// file: verif/switch_cfg_space_address_map_tb_top.sv
// self-checking bench for the configuration address map
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("Error %s expected %h seen %h", nm, e, g); n_fail++; end end
module switch_cfg_space_address_map_tb_top;
  // ********
  // wiring
  // ********
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        ce = 1'b1; // low only in the freeze test: answers then come late
  int          n_fail = 0;
  int          n_compared = 0;
  logic [31:0] ref_mem [int];
  logic [11:0] offs [14] = '{12'h000, 12'h070, 12'h074, 12'h0C4, 12'h0C8, 12'h0D0, 12'h0DC,
                             12'h0E0, 12'h0F8, 12'h14C, 12'h150, 12'h400, 12'h5FC, 12'h600};
  wire         cfg_req, cfg_we, cfg_ack_r, smb_req, smb_we, smb_ack_r, eep_req, eep_ack_r;
  wire         acc_undef_r;
  wire  [15:0] cfg_a, smb_addr, eep_addr;
  wire  [3:0]  cfg_be, smb_be, eep_be;
  wire  [31:0] cfg_wdata, smb_wdata, eep_wdata, cfg_rdata_r, smb_rdata_r;

  always #50 clk_sys = ~clk_sys;

  scm_req_model u_cfg (.clk_sys, .ack(cfg_ack_r), .rdata(cfg_rdata_r), .req(cfg_req),
                       .we(cfg_we), .addr(cfg_a), .be(cfg_be), .wdata(cfg_wdata));
  scm_req_model u_smb (.clk_sys, .ack(smb_ack_r), .rdata(smb_rdata_r), .req(smb_req),
                       .we(smb_we), .addr(smb_addr), .be(smb_be), .wdata(smb_wdata));
  scm_req_model u_eep (.clk_sys, .ack(eep_ack_r), .rdata(32'h0), .req(eep_req),
                       .we(), .addr(eep_addr), .be(eep_be), .wdata(eep_wdata));
  scm_addr_map uut (.clk_sys, .arst_n, .ce, .cfg_req, .cfg_we, .cfg_port(cfg_a[14:12]),
                    .cfg_off(cfg_a[11:0]), .cfg_be, .cfg_wdata, .cfg_ack_r, .cfg_rdata_r,
                    .smb_req, .smb_we, .smb_addr, .smb_be, .smb_wdata, .smb_ack_r,
                    .smb_rdata_r, .eep_req, .eep_addr, .eep_be, .eep_wdata, .eep_ack_r,
                    .acc_undef_r);
  // ********
  // expectations and access
  // ********
  function automatic bit defd(input logic [15:0] a);
    logic [11:0] o;
    o = a[11:0];
    if (a[15:12] > 4'h6) return 1'b0;
    if (o < 12'h074 || (o >= 12'h0C0 && o < 12'h0C8) || (o >= 12'h0F8 && o < 12'h150))
      return 1'b1;
    if (a[15:12] == 4'h0) return o >= 12'h400 && o < 12'h600;
    return o >= 12'h0D0 && o < 12'h0E0;
  endfunction

  task automatic acc(input int src, input logic w, input logic [15:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    logic [31:0] q;
    logic [31:0] e;
    logic        ok;
    int          k;
    k = {a[15:2], 2'b00};
    e = ref_mem.exists(k) ? ref_mem[k] : 'x;
    case (src)
      0: u_cfg.access(w, a, b, d, q, ok);
      1: u_smb.access(w, a, b, d, q, ok);
      default: u_eep.access(1'b1, a, b, d, q, ok);
    endcase
    w = w || src == 2;
    `CHK("ack", 1'b1, ok)
    `CHK("undef flag", !defd(a), acc_undef_r)
    if (w && defd(a))
    begin
      for (int i = 0; i < 4; i++)
        if (b[i]) e[8*i +: 8] = d[8*i +: 8];
      ref_mem[k] = e;
    end
    else if (!w && !defd(a))
      `CHK("undef read", src == 0 ? 32'h0 : 32'hFFFFFFFF, q)
    else if (!w && ref_mem.exists(k))
      `CHK("read data", e, q)
  endtask

  task automatic end_of_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ********
  // tests
  // ********
  initial
  begin
    logic [15:0] a;
    int          s;
    void'($urandom(25082));
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    for (int p = 0; p < 7; p++)
    begin
      a = 16'h0010 + 16'(p) * 16'h1000;
      acc(2, 1'b1, a, 4'hF, $urandom);
      acc(0, 1'b0, a, 4'h0, 32'h0);
      acc(1, 1'b0, a, 4'h0, 32'h0);
    end
    $display("test port_bases done");
    foreach (offs[i])
      for (int p = 0; p < 7; p += 3)
      begin
        a = {1'b0, p[2:0], offs[i]};
        acc(1, 1'b1, a, 4'hF, $urandom);
        acc(0, 1'b0, a, 4'h0, 32'h0);
        acc(1, 1'b0, a, 4'h0, 32'h0);
      end
    $display("test region_edges done");
    acc(0, 1'b1, 16'h7010, 4'hF, $urandom);
    acc(1, 1'b1, 16'h8010, 4'hF, $urandom);
    acc(0, 1'b0, 16'h0010, 4'h0, 32'h0);
    $display("test alias_writes done");
    fork
      acc(0, 1'b0, 16'h0010, 4'h0, 32'h0);
      acc(1, 1'b0, 16'h1010, 4'h0, 32'h0);
      acc(2, 1'b1, 16'h2010, 4'hF, 32'hA5C30F1E);
    join
    $display("test contention done");
    fork
      acc(0, 1'b0, 16'h2010, 4'h0, 32'h0);
      begin
        repeat (2) @(posedge clk_sys);
        ce <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK("frozen ack", 1'b0, cfg_ack_r)
        ce <= 1'b1;
      end
    join
    $display("test clock_enable done");
    repeat (150)
    begin
      s = $urandom % 3;
      a[15:12] = (s == 1) ? 4'($urandom) : 4'($urandom % 8);
      a[11:0] = ($urandom % 2) ? offs[$urandom % 14] : 12'($urandom) & 12'hFFC;
      acc(s, 1'($urandom), a, ref_mem.exists(a) ? 4'($urandom) : 4'hF, $urandom);
    end
    $display("test random_mix done");
    end_of_test();
  end

  // about 300 accesses of five cycles each; five times that is ample
  initial
  begin
    #800000;
    n_fail++;
    end_of_test();
  end
endmodule // switch_cfg_space_address_map_tb_top
`default_nettype wire
